// ===== imf_pkg.sv
package imf_pkg;
  // Register byte offsets.
  localparam logic [15:0] A_CTRL    = 16'h0104; // Control word.
  localparam logic [15:0] A_STAT    = 16'h0110; // Operation status word.
  localparam logic [15:0] A_IRQ_ST  = 16'h0114; // Sticky event bits.
  localparam logic [15:0] A_IRQ_CLR = 16'h0118; // Write-one-to-clear events.
  localparam logic [15:0] A_IRQ_EN  = 16'h011c; // Event enables.
  localparam logic [15:0] A_MAC_HI  = 16'h0300; // Switch address [47:32].
  localparam logic [15:0] A_MAC_LO  = 16'h0304; // Switch address [31:0].
  // Control fields and reset values.
  localparam int          C_DCHK     = 30;            // Destination check enable.
  localparam int          C_RST      = 29;            // Self-clearing machine reset.
  localparam int          C_PORT     = 16;            // Port selector low bit.
  localparam logic [31:0] CTRL_WMASK = 32'h6007ffff;  // Writable control bits.
  localparam logic [31:0] CTRL_RST   = 32'h000040fe;  // Control reset value.
  localparam logic [47:0] MAC_RST    = 48'h0010a1ffffff; // Switch address reset.
  // Status fields.
  localparam int          S_GOOD = 31; // Good frame.
  localparam int          S_TXD  = 30; // Response sent.
  localparam int          S_EXD  = 29; // Commands executed.
  localparam int          S_DAE  = 14; // Address mismatch.
  localparam int          S_FMT  = 13; // Access format error.
  localparam int          S_ACE  = 12; // Access code error.
  localparam int          S_CMD  = 11; // Command code error.
  localparam int          S_OVS  = 10; // Oversize frame.
  localparam logic [31:0] S_CLR  = 32'h60007c7f; // Bits cleared by a tagged frame.
  // Event bits of the interrupt registers.
  localparam int IRQ_W = 4;    // Event count.
  localparam int E_GOOD = 0;   // Good frame accepted.
  localparam int E_TXD  = 1;   // Response sent.
  localparam int E_EXD  = 2;   // Execution finished.
  localparam int E_ERR  = 3;   // Any error flag raised.
  // Frame layout and codes.
  localparam int          P_SA      = 6;   // Source address byte.
  localparam int          P_ET      = 12;  // EtherType byte.
  localparam int          P_FMT     = 16;  // Access format byte.
  localparam int          P_ACODE   = 18;  // Access code byte.
  localparam int          P_CMD     = 20;  // First command byte.
  localparam int          CMD_BYTES = 7;   // Code, address, data.
  localparam int          MAX_FRAME = 320; // Largest legal frame in bytes.
  localparam logic [15:0] FMT_OK    = 16'h9800; // Accepted access format.
  localparam logic [15:0] ACODE_A   = 16'h0001; // First legal access code.
  localparam logic [15:0] ACODE_B   = 16'h0002; // Second legal access code.
  localparam logic [7:0]  CMD_END   = 8'h00;    // End of command list.
  localparam logic [7:0]  CMD_WR    = 8'h01;    // Register write.
  localparam logic [7:0]  CMD_RD    = 8'h02;    // Register read.
  // Received byte from the switch fabric.
  typedef struct packed {
    logic       valid; logic sof; logic eof; logic [2:0] port; logic [7:0] data;
  } imf_rx_t;
  // Register access issued by a command.
  typedef struct packed {
    logic valid; logic write; logic [15:0] addr; logic [31:0] wdata;
  } imf_acc_t;
  // Response byte to the selected port.
  typedef struct packed { logic valid; logic last; logic [7:0] data; } imf_tx_t;
  // Frame machine states.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_RX = 6'h02, ST_EXEC = 6'h04, ST_RDW = 6'h08, ST_TX = 6'h10
  } imf_state_t;
endpackage

// ===== imf_top.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
// Summary of operation
// (RQ1) Good frame sets status bit 31.
// (RQ2) Response sent sets status bit 30.
// (RQ3) All commands executed sets status bit 29.
// (RQ4) Tagged frame clears done and error flags.
// (RQ5) Address mismatch flag when checking enabled.
// (RQ6) Wrong access format sets bit 13.
// (RQ7) Only two access codes; else bit 12.
// (RQ8) Unknown command code sets bit 11.
// (RQ9) Over 320 bytes: flag, no response.
// (RQ10) Bad command location in bits 6:0.
// (RQ11) Checked non-matching destination frames are discarded.
// (RQ12) Frames exchanged only on selected port.
// (RQ13) Frames identified by programmable EtherType.
// (RQ14) Self-clearing bit resets frame machine.
// (RQ15) Rejected frames execute no command.
module imf_top #(
  parameter int CMD_MAX = 8  // Commands buffered per frame.
) (
  input  wire logic                i_mclk,   // Core clock.
  input  wire logic                i_nrst,   // Synchronous reset, active low.
  input  wire logic [15:0]         i_addr,   // Register address.
  input  wire logic [31:0]         i_wdata,  // Register write data.
  input  wire logic                i_wr,     // Write strobe.
  input  wire logic                i_rd,     // Read strobe.
  output logic [31:0]              o_rdata,  // Read data, next cycle.
  output logic                     o_irq,    // Level interrupt.
  input  wire imf_pkg::imf_rx_t    i_rx,     // Received frame bytes.
  output imf_pkg::imf_tx_t         o_tx,     // Response frame bytes.
  input  wire logic                i_tx_rdy, // Response byte taken.
  output imf_pkg::imf_acc_t        o_acc,    // Register access by command.
  input  wire logic [31:0]         i_acc_rd  // Read result while o_acc valid.
);
  localparam int BUF = imf_pkg::P_CMD + imf_pkg::CMD_BYTES * CMD_MAX; // Stored bytes.

  imf_pkg::imf_state_t state_q, state_d;   // Frame machine.
  logic [7:0]  buf_q [BUF];                // Stored frame head.
  logic [7:0]  buf_d [BUF];                // Next stored bytes.
  logic [8:0]  cnt_q, cnt_d;               // Received byte count.
  logic [2:0]  ph_q, ph_d;                 // Byte phase inside a command.
  logic        cend_q, cend_d;             // End code already seen.
  logic        cerr_q, cerr_d;             // Bad command code seen.
  logic [6:0]  cloc_q, cloc_d;             // Its byte position.
  logic        hit_q, hit_d;               // EtherType matched.
  logic [3:0]  k_q, k_d;                   // Command being executed.
  logic [8:0]  tidx_q, tidx_d;             // Next response byte.
  logic [31:0] ctrl_q, ctrl_d;             // Control word.
  logic [47:0] mac_q, mac_d;               // Switch address.
  logic [31:0] stat_q, stat_d;             // Operation status.
  logic [imf_pkg::IRQ_W-1:0] ist_q, ist_d; // Sticky events.
  logic [imf_pkg::IRQ_W-1:0] ien_q, ien_d; // Event enables.
  logic        irq_q, irq_d;               // Interrupt output register.
  logic [31:0] rdat_q, rdat_d;             // Read data register.
  imf_pkg::imf_acc_t acc_q, acc_d;         // Access output register.
  imf_pkg::imf_tx_t  tx_q, tx_d;           // Response output register.

  // Two stored bytes as a big-endian half word.
  function automatic logic [15:0] get16(input int i);
    get16 = {buf_q[i], buf_q[i+1]};
  endfunction

  // First byte of command k.
  function automatic int cbase(input logic [3:0] k);
    cbase = imf_pkg::P_CMD + imf_pkg::CMD_BYTES * int'(k);
  endfunction

  // Response byte i: received source as destination, switch address as source, rest echoed with read results.
  function automatic logic [7:0] txbyte(input int i);
    if (i < imf_pkg::P_SA) begin
      txbyte = buf_q[i + imf_pkg::P_SA];
    end else if (i < imf_pkg::P_ET) begin
      txbyte = mac_q[8*(imf_pkg::P_ET-1-i) +: 8];
    end else begin
      txbyte = buf_q[i];
    end
  endfunction

  // All next-state logic of registers, frame machine and outputs.
  always_comb begin
    logic        take;   // Byte accepted this cycle.
    int          idx;    // Position of that byte.
    logic        hit;    // EtherType match including this byte.
    logic [47:0] da;     // Received destination address.
    logic        dae, fmt, ace, ovs; // Frame checks at end of frame.
    logic [7:0]  code;   // Command code under execution.
    int          b;      // Its byte position.
    logic [imf_pkg::IRQ_W-1:0] ev;  // Events this cycle.
    take = 1'b0; idx = 0; hit = 1'b0; da = '0;
    dae = 1'b0; fmt = 1'b0; ace = 1'b0; ovs = 1'b0;
    code = '0; b = 0; ev = '0;
    state_d = state_q; buf_d = buf_q; cnt_d = cnt_q; ph_d = ph_q;
    cend_d = cend_q; cerr_d = cerr_q; cloc_d = cloc_q; hit_d = hit_q;
    k_d = k_q; tidx_d = tidx_q; stat_d = stat_q;
    ctrl_d = ctrl_q; mac_d = mac_q; ien_d = ien_q;
    rdat_d = '0; acc_d = '0; tx_d = tx_q;
    ctrl_d[imf_pkg::C_RST] = 1'b0; // RQ14

    // Register reads answer in the next cycle; unmapped reads give zero.
    if (i_rd) begin
      if (i_addr == imf_pkg::A_CTRL) begin
        rdat_d = ctrl_q;
      end else if (i_addr == imf_pkg::A_STAT) begin
        rdat_d = stat_q;
      end else if (i_addr == imf_pkg::A_IRQ_ST) begin
        rdat_d = 32'(ist_q);
      end else if (i_addr == imf_pkg::A_IRQ_EN) begin
        rdat_d = 32'(ien_q);
      end else if (i_addr == imf_pkg::A_MAC_HI) begin
        rdat_d = {16'h0000, mac_q[47:32]};
      end else if (i_addr == imf_pkg::A_MAC_LO) begin
        rdat_d = mac_q[31:0];
      end
    end

    // Register writes; status is read-only and unmapped writes are dropped.
    if (i_wr) begin
      if (i_addr == imf_pkg::A_CTRL) begin
        ctrl_d = i_wdata & imf_pkg::CTRL_WMASK; // RQ13
      end else if (i_addr == imf_pkg::A_IRQ_EN) begin
        ien_d = i_wdata[imf_pkg::IRQ_W-1:0];
      end else if (i_addr == imf_pkg::A_MAC_HI) begin
        mac_d[47:32] = i_wdata[15:0];
      end else if (i_addr == imf_pkg::A_MAC_LO) begin
        mac_d[31:0] = i_wdata;
      end
    end

    // Bytes are taken only from the selected port.
    if (i_rx.valid && i_rx.port == ctrl_q[imf_pkg::C_PORT +: 3]) begin // RQ12
      if (state_q == imf_pkg::ST_IDLE && i_rx.sof) begin
        take = 1'b1;
        cnt_d = '0; ph_d = '0; cend_d = 1'b0; cerr_d = 1'b0; hit_d = 1'b0;
      end else if (state_q == imf_pkg::ST_RX) begin
        take = 1'b1;
        idx = int'(cnt_q);
      end
    end

    // Store the byte and run the running checks.
    if (take) begin
      state_d = imf_pkg::ST_RX;
      if (cnt_d != 9'h1ff) begin
        cnt_d = 9'(idx + 1);
      end
      if (idx < BUF) begin
        buf_d[idx] = i_rx.data;
      end
      hit = hit_q;
      if (idx == imf_pkg::P_ET + 1) begin
        hit = {buf_q[imf_pkg::P_ET], i_rx.data} == ctrl_q[15:0]; // RQ13
        hit_d = hit;
        if (hit) begin
          stat_d = stat_q & ~imf_pkg::S_CLR; // RQ4
        end
      end
      // Command codes are checked as they pass, every seventh byte.
      if (idx >= imf_pkg::P_CMD && idx < BUF) begin
        ph_d = (ph_q == 3'(imf_pkg::CMD_BYTES - 1)) ? 3'h0 : ph_q + 3'h1;
        if (ph_q == 3'h0 && !cend_q && !cerr_q) begin
          if (i_rx.data == imf_pkg::CMD_END) begin
            cend_d = 1'b1;
          end else if (i_rx.data != imf_pkg::CMD_WR && i_rx.data != imf_pkg::CMD_RD) begin
            cerr_d = 1'b1; // RQ8
            cloc_d = 7'(idx); // RQ10
          end
        end
      end
      // End of frame: judge the whole frame.
      if (i_rx.eof) begin
        state_d = imf_pkg::ST_IDLE;
        if (hit) begin
          for (int j = 0; j < 6; j++) begin
            da[8*(5-j) +: 8] = buf_q[j];
          end
          dae = ctrl_q[imf_pkg::C_DCHK] && da != mac_q; // RQ5 RQ11
          fmt = get16(imf_pkg::P_FMT) != imf_pkg::FMT_OK; // RQ6
          ace = get16(imf_pkg::P_ACODE) != imf_pkg::ACODE_A
             && get16(imf_pkg::P_ACODE) != imf_pkg::ACODE_B; // RQ7
          ovs = int'(cnt_d) > imf_pkg::MAX_FRAME; // RQ9
          stat_d[imf_pkg::S_DAE] = stat_d[imf_pkg::S_DAE] | dae; // RQ5
          stat_d[imf_pkg::S_FMT] = stat_d[imf_pkg::S_FMT] | fmt; // RQ6
          stat_d[imf_pkg::S_ACE] = stat_d[imf_pkg::S_ACE] | ace; // RQ7
          stat_d[imf_pkg::S_CMD] = stat_d[imf_pkg::S_CMD] | cerr_d; // RQ8
          stat_d[imf_pkg::S_OVS] = stat_d[imf_pkg::S_OVS] | ovs; // RQ9
          if (cerr_d) begin
            stat_d[6:0] = cloc_d; // RQ10
          end
          ev[imf_pkg::E_ERR] = dae | fmt | ace | cerr_d | ovs;
          if (dae || ovs) begin
            state_d = imf_pkg::ST_IDLE; // RQ9 RQ11
          end else if (fmt || ace || cerr_d) begin
            state_d = imf_pkg::ST_TX; // RQ15
            tidx_d = '0;
          end else begin
            stat_d[imf_pkg::S_GOOD] = 1'b1; // RQ1
            ev[imf_pkg::E_GOOD] = 1'b1;
            state_d = imf_pkg::ST_EXEC;
            k_d = '0;
          end
        end
      end
    end

    // Execution and response.
    case (state_q)
      imf_pkg::ST_EXEC: begin
        b = cbase(k_q);
        code = (int'(k_q) < CMD_MAX) ? buf_q[b] : imf_pkg::CMD_END;
        if (code == imf_pkg::CMD_WR || code == imf_pkg::CMD_RD) begin
          acc_d.valid = 1'b1;
          acc_d.write = code == imf_pkg::CMD_WR;
          acc_d.addr  = get16(b + 1);
          acc_d.wdata = {get16(b + 3), get16(b + 5)};
          if (code == imf_pkg::CMD_RD) begin
            state_d = imf_pkg::ST_RDW;
          end else begin
            k_d = k_q + 4'h1;
          end
        end else begin
          stat_d[imf_pkg::S_EXD] = 1'b1; // RQ3
          ev[imf_pkg::E_EXD] = 1'b1;
          state_d = imf_pkg::ST_TX;
          tidx_d = '0;
        end
      end
      imf_pkg::ST_RDW: begin
        b = cbase(k_q);
        for (int j = 0; j < 4; j++) begin
          buf_d[b+3+j] = i_acc_rd[8*(3-j) +: 8];
        end
        k_d = k_q + 4'h1;
        state_d = imf_pkg::ST_EXEC;
      end
      imf_pkg::ST_TX: begin
        if (tx_q.valid && i_tx_rdy && tx_q.last) begin
          tx_d = '0;
          stat_d[imf_pkg::S_TXD] = 1'b1; // RQ2
          ev[imf_pkg::E_TXD] = 1'b1;
          state_d = imf_pkg::ST_IDLE;
        end else if (!tx_q.valid || i_tx_rdy) begin
          tx_d.valid = 1'b1;
          tx_d.data  = txbyte(int'(tidx_q));
          tx_d.last  = int'(tidx_q) == BUF - 1;
          tidx_d = tidx_q + 9'h1;
        end
      end
      default: begin
      end
    endcase

    // Machine reset abandons any frame and clears status.
    if (ctrl_q[imf_pkg::C_RST]) begin
      state_d = imf_pkg::ST_IDLE; // RQ14
      stat_d = '0;
      tx_d = '0;
      acc_d = '0;
      ev = '0;
    end

    // Events win over a clear in the same cycle.
    ist_d = ist_q;
    if (i_wr && i_addr == imf_pkg::A_IRQ_CLR) begin
      ist_d = ist_q & ~i_wdata[imf_pkg::IRQ_W-1:0];
    end
    ist_d = ist_d | ev;
    irq_d = |(ist_d & ien_d);
  end

  // Registers only.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_q <= imf_pkg::ST_IDLE;
      for (int j = 0; j < BUF; j++) begin
        buf_q[j] <= '0;
      end
      cnt_q <= '0; ph_q <= '0; cend_q <= 1'b0; cerr_q <= 1'b0;
      cloc_q <= '0; hit_q <= 1'b0; k_q <= '0; tidx_q <= '0;
      ctrl_q <= imf_pkg::CTRL_RST;
      mac_q  <= imf_pkg::MAC_RST;
      stat_q <= '0; ist_q <= '0; ien_q <= '0; irq_q <= 1'b0;
      rdat_q <= '0; acc_q <= '0; tx_q <= '0;
    end else begin
      state_q <= state_d;
      buf_q   <= buf_d;
      cnt_q <= cnt_d; ph_q <= ph_d; cend_q <= cend_d; cerr_q <= cerr_d;
      cloc_q <= cloc_d; hit_q <= hit_d; k_q <= k_d; tidx_q <= tidx_d;
      ctrl_q <= ctrl_d;
      mac_q  <= mac_d;
      stat_q <= stat_d; ist_q <= ist_d; ien_q <= ien_d; irq_q <= irq_d;
      rdat_q <= rdat_d; acc_q <= acc_d; tx_q <= tx_d;
    end
  end

  assign o_rdata = rdat_q;
  assign o_irq   = irq_q;
  assign o_tx    = tx_q;
  assign o_acc   = acc_q;
endmodule // imf_top

// ===== imf_properties.sv
`timescale 1ns/10ps
// Watches the management frame block from its ports only.
module imf_properties #(
  parameter int CMD_MAX = 8 // Commands per frame.
) (
  input wire logic              i_mclk,   // Clock.
  input wire logic              i_nrst,   // Reset, low.
  input wire logic [15:0]       i_addr,   // Address.
  input wire logic [31:0]       i_wdata,  // Write data.
  input wire logic              i_wr,     // Write strobe.
  input wire logic              i_rd,     // Read strobe.
  input wire logic [31:0]       o_rdata,  // Read data.
  input wire logic              o_irq,    // Interrupt.
  input wire imf_pkg::imf_rx_t  i_rx,     // Frame bytes in.
  input wire imf_pkg::imf_tx_t  o_tx,     // Response bytes.
  input wire logic              i_tx_rdy, // Response taken.
  input wire imf_pkg::imf_acc_t o_acc,    // Command access.
  input wire logic [31:0]       i_acc_rd  // Command read data.
);
  logic [2:0]  port_q; // Shadow of the port selector.
  logic [3:0]  en_q;   // Shadow of the event enables.
  logic [1:0]  mr_q;   // Cycles left after a machine reset.
  logic [8:0]  cnt_q;  // Bytes taken of this frame.
  logic [15:0] fmt_q;  // Access format of this frame.
  logic [15:0] code_q; // Access code of this frame.
  logic        ovs_q;  // Last frame was too long.
  logic        rej_q;  // Last frame may run no command.
  logic        ctl_wr; // Control register write.
  logic        take;   // Byte of the selected port.
  logic [8:0]  idx;    // Position of that byte.
  assign ctl_wr = i_wr && (i_addr == imf_pkg::A_CTRL);
  assign take   = i_rx.valid && (i_rx.port == port_q);
  assign idx    = i_rx.sof ? 9'h000 : cnt_q;
  // Tracks the registers and frame fields that the properties depend on.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      port_q <= 3'h0;
      en_q   <= 4'h0;
      mr_q   <= 2'h0;
      cnt_q  <= 9'h000;
      ovs_q  <= 1'b0;
      rej_q  <= 1'b0;
    end else begin
      if (ctl_wr) port_q <= i_wdata[18:16];
      if (i_wr && (i_addr == imf_pkg::A_IRQ_EN)) en_q <= i_wdata[3:0];
      mr_q <= (ctl_wr && i_wdata[imf_pkg::C_RST]) ? 2'h3 : mr_q - {1'b0, mr_q != 2'h0};
      if (take) begin
        cnt_q <= idx + 9'h001;
        if (idx == 9'h010) fmt_q[15:8] <= i_rx.data;
        if (idx == 9'h011) fmt_q[7:0] <= i_rx.data;
        if (idx == 9'h012) code_q[15:8] <= i_rx.data;
        if (idx == 9'h013) code_q[7:0] <= i_rx.data;
        ovs_q <= i_rx.eof ? (idx >= 9'h140) : (ovs_q && !i_rx.sof);
        rej_q <= i_rx.eof ? ((idx >= 9'h140) || (fmt_q != imf_pkg::FMT_OK) ||
                 ((code_q != imf_pkg::ACODE_A) && (code_q != imf_pkg::ACODE_B)))
                 : (rej_q && !i_rx.sof);
      end
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_clear_reads_zero: assert property (i_rd && i_addr == imf_pkg::A_IRQ_CLR |=> o_rdata == 32'h0)
    else $error("clear register did not read zero");
  chk_tx_holds: assert property (
    o_tx.valid && !i_tx_rdy && !ctl_wr && mr_q == 2'h0 |=> o_tx.valid && $stable(o_tx))
    else $error("response byte changed before it was taken");
  chk_exec_before_tx: assert property (o_tx.valid |-> !o_acc.valid)
    else $error("command access during response");
  chk_read_spacing: assert property (o_acc.valid && !o_acc.write |=> !o_acc.valid)
    else $error("command read not followed by an idle cycle");
  chk_oversize_quiet: assert property (ovs_q |-> !o_tx.valid)
    else $error("response to an oversize frame");
  chk_reject_no_exec: assert property (rej_q |-> !o_acc.valid)
    else $error("command run from a rejected frame");
  chk_mreset_idle: assert property (ctl_wr && i_wdata[imf_pkg::C_RST] |->
    ##3 (!o_tx.valid && !o_acc.valid))
    else $error("machine still active after its reset");
  chk_irq_masked: assert property (en_q == 4'h0 && $past(en_q) == 4'h0 |-> !o_irq)
    else $error("interrupt with all events disabled");
  chk_reset_quiet: assert property ($rose(i_nrst) |->
    o_tx == '0 && o_acc == '0 && o_rdata == 32'h0 && !o_irq)
    else $error("outputs not quiet after reset");
endmodule // imf_properties

bind imf_top imf_properties #(.CMD_MAX(CMD_MAX)) u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .i_rx(i_rx), .o_tx(o_tx), .i_tx_rdy(i_tx_rdy), .o_acc(o_acc),
  .i_acc_rd(i_acc_rd));

// ===== imf_host_model.sv
`timescale 1ns/10ps
// Remote manager: sends frames a byte a cycle and takes the response bytes.
module imf_host_model (
  input  wire logic             i_mclk,   // Clock.
  output imf_pkg::imf_rx_t      o_rx,     // Frame bytes to the switch.
  output logic                  o_tx_rdy, // Response byte taken.
  input  wire imf_pkg::imf_tx_t i_tx      // Response bytes.
);
  logic [7:0] mem [0:399]; // Frame image loaded by the bench.
  logic [7:0] rsp [0:75];  // Response bytes in order.
  int         n_rsp = 0;   // Response bytes taken so far.
  int         mode = 0;    // Pacing: 0 prompt, 1 every other cycle, 2 stalled.
  initial begin
    o_rx = '0;
    o_tx_rdy = 1'b0;
  end
  // Takes response bytes; ready follows the pacing mode.
  always @(posedge i_mclk) begin
    if (i_tx.valid && o_tx_rdy) begin
      rsp[n_rsp % 76] <= i_tx.data;
      n_rsp <= n_rsp + 1;
    end
    o_tx_rdy <= (mode == 0) || (mode == 1 && !o_tx_rdy);
  end
  // Sends one frame; afterwards the data line shows the inverse of its last byte.
  task automatic send(input int len, input logic [2:0] port);
    for (int i = 0; i < len; i++) begin
      @(posedge i_mclk);
      o_rx <= '{valid: 1'b1, sof: i == 0, eof: i == len - 1, port: port, data: mem[i]};
    end
    @(posedge i_mclk);
    o_rx <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, port: port, data: ~mem[len - 1]};
  endtask
endmodule // imf_host_model

// ===== tb_inband_mgmt_frame_status.sv
`timescale 1ns/10ps
// Register traffic and frames from a modelled remote manager.
module tb_inband_mgmt_frame_status;
  logic              i_mclk = 1'b0;   // Clock.
  logic              i_nrst = 1'b0;   // Reset, low.
  logic [15:0]       i_addr = 16'h0;  // Address.
  logic [31:0]       i_wdata = 32'h0; // Write data.
  logic              i_wr = 1'b0;     // Write strobe.
  logic              i_rd = 1'b0;     // Read strobe.
  logic [31:0]       rdata;           // Read data.
  logic              irq;             // Interrupt.
  imf_pkg::imf_rx_t  rx;              // Frame bytes.
  imf_pkg::imf_tx_t  tx;              // Response bytes.
  logic              tx_rdy;          // Response taken.
  imf_pkg::imf_acc_t acc;             // Command accesses.
  logic [31:0]       acc_rd;          // Read result to commands.
  logic [47:0]       w_last;          // Last command write.
  int                n_errors = 0;    // Mismatches.
  int                n_checks = 0;    // Comparisons.
  int                n_acc = 0;       // Command accesses.
  localparam logic [95:0] HDR = {48'h021122334455, imf_pkg::MAC_RST}; // Response addresses.
  logic [15:0] r_adr [8] = '{16'h0104, 16'h0110, 16'h0114, 16'h0118, 16'h011c, 16'h0300,
                             16'h0304, 16'h0200};
  logic [31:0] r_val [8] = '{32'h000040fe, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00000010,
                             32'ha1ffffff, 32'h0};
  logic [15:0] e_fmt [4] = '{16'h9801, 16'h9800, 16'h9800, 16'h9800}; // Three error cases, then a good frame with the second access code.
  logic [15:0] e_cod [4] = '{16'h0001, 16'h0003, 16'h0001, 16'h0002};
  logic [7:0]  e_cmd [4] = '{8'h01, 8'h01, 8'h07, 8'h01};
  logic [31:0] e_st [4]  = '{32'h00002000, 32'h00001000, 32'h00000814, 32'h0};
  int          e_acc [4] = '{0, 0, 0, 2};
  always #20 i_mclk = ~i_mclk;
  imf_top #(.CMD_MAX(8)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_irq(irq), .i_rx(rx),
    .o_tx(tx), .i_tx_rdy(tx_rdy), .o_acc(acc), .i_acc_rd(acc_rd));
  imf_host_model host (.i_mclk(i_mclk), .o_rx(rx), .o_tx_rdy(tx_rdy), .i_tx(tx));
  assign acc_rd = {16'h5a5a, acc.addr};
  // Register peripheral: counts command accesses and keeps the last write.
  always @(posedge i_mclk) begin
    if (acc.valid === 1'b1) n_acc <= n_acc + 1;
    if (acc.valid === 1'b1 && acc.write === 1'b1) w_last <= {acc.addr, acc.wdata};
  end
  // Counts one comparison and reports a failed one.
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Reads a register and compares the masked word.
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, msk);
    @(posedge i_mclk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk((rdata & msk) === (exp & msk), "register read");
  endtask
  // Builds a frame: write command, read command, end code, zero padding.
  task automatic mk(input logic [15:0] fmt, cod, et, input logic [7:0] c0, input logic [47:0] da);
    logic [279:0] h;
    h = {da, 48'h021122334455, et, 16'h0, fmt, cod, c0, 48'h0500deadbeef, 56'h02050400000000,
         8'h00};
    for (int i = 0; i < 400; i++) host.mem[i] = (i < 35) ? h[8 * (34 - i) +: 8] : 8'h00;
  endtask
  task automatic good();
    mk(16'h9800, 16'h0001, 16'h40fe, 8'h01, imf_pkg::MAC_RST);
  endtask
  // Sends a frame, waits for its response if one is due, then checks status.
  task automatic run(input int len, input logic [2:0] port, input logic [31:0] exp, msk,
                     input int rsp, input int na);
    int want;
    int a0;
    want = host.n_rsp + rsp * 76;
    a0 = n_acc;
    host.send(len, port);
    for (int w = 0; w < 600 && host.n_rsp != want; w++) @(posedge i_mclk);
    repeat (4) @(posedge i_mclk);
    chk(host.n_rsp == want, "response byte count");
    chk(n_acc == a0 + na, "command access count");
    rd(imf_pkg::A_STAT, exp, msk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (40000) @(posedge i_mclk);
    n_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    wr(imf_pkg::A_STAT, 32'hffffffff);
    for (int k = 0; k < 8; k++) rd(r_adr[k], r_val[k], 32'hffffffff);
    $display("test registers done");
    host.mode = 1;
    good();
    run(64, 3'h0, 32'he0000000, 32'hffffffff, 1, 2);
    for (int i = 0; i < 12; i++) chk(host.rsp[i] === HDR[8 * (11 - i) +: 8], "response address");
    chk({host.rsp[30], host.rsp[31], host.rsp[32], host.rsp[33]} === 32'h5a5a0504,
        "read result in response");
    chk(w_last === 48'h0500deadbeef, "command write");
    rd(imf_pkg::A_IRQ_ST, 32'h7, 32'hf);
    chk(irq === 1'b0, "masked interrupt");
    wr(imf_pkg::A_IRQ_EN, 32'hf);
    repeat (2) @(posedge i_mclk);
    #1 chk(irq === 1'b1, "enabled interrupt");
    wr(imf_pkg::A_IRQ_CLR, 32'hf);
    repeat (2) @(posedge i_mclk);
    #1 chk(irq === 1'b0, "cleared interrupt");
    rd(imf_pkg::A_IRQ_ST, 32'h0, 32'hf);
    $display("test good frame done");
    host.mode = 0;
    for (int k = 0; k < 4; k++) begin
      mk(e_fmt[k], e_cod[k], 16'h40fe, e_cmd[k], imf_pkg::MAC_RST);
      run(64, 3'h0, e_st[k], 32'h00007c7f, 1, e_acc[k]);
    end
    good();
    run(320, 3'h0, 32'h0, 32'h00007c7f, 1, 2);
    run(321, 3'h0, 32'h400, 32'h00007c7f, 0, 0);
    run(64, 3'h1, 32'h400, 32'h00007c7f, 0, 0);
    wr(imf_pkg::A_CTRL, 32'h000140fe);
    run(64, 3'h1, 32'h0, 32'h00007c7f, 1, 2);
    wr(imf_pkg::A_CTRL, 32'h00001234);
    mk(16'h9801, 16'h0001, 16'h40fe, 8'h01, imf_pkg::MAC_RST);
    run(64, 3'h0, 32'h0, 32'h00007c7f, 0, 0);
    mk(16'h9801, 16'h0001, 16'h1234, 8'h01, imf_pkg::MAC_RST);
    run(64, 3'h0, 32'h2000, 32'h00007c7f, 1, 0);
    wr(imf_pkg::A_CTRL, 32'h400040fe);
    mk(16'h9800, 16'h0002, 16'h40fe, 8'h01, imf_pkg::MAC_RST ^ 48'h1);
    run(64, 3'h0, 32'h4000, 32'h00007c7f, 0, 0);
    wr(imf_pkg::A_CTRL, 32'h000040fe);
    run(64, 3'h0, 32'h0, 32'h00007c7f, 1, 2);
    $display("test frame checks done");
    host.mode = 2;
    good();
    host.send(64, 3'h0);
    for (int w = 0; w < 300 && tx.valid !== 1'b1; w++) @(posedge i_mclk);
    chk(tx.valid === 1'b1, "response pending");
    wr(imf_pkg::A_CTRL, 32'h200040fe);
    repeat (3) @(posedge i_mclk);
    #1 chk(tx.valid === 1'b0, "response dropped");
    rd(imf_pkg::A_CTRL, 32'h000040fe, 32'hffffffff);
    rd(imf_pkg::A_STAT, 32'h0, 32'hffffffff);
    host.mode = 0;
    run(64, 3'h0, 32'he0000000, 32'hffffffff, 1, 2);
    $display("test machine reset done");
    give_verdict();
  end
endmodule // tb_inband_mgmt_frame_status
